// ### src/twlr_pkg.sv
// Package of constants for the track write lockout and ready logic.
package twlr_pkg;

  localparam int TRACK_W        = 8;
  localparam int GROUP_COUNT    = 16;
  localparam int GROUP_LSB      = 4;
  localparam int SUPPLY_COUNT   = 3;
  localparam int CLK_HZ         = 40000000;
  localparam int SPEED_WIN_US   = 100;
  localparam int SPEED_WIN_CYC  = (CLK_HZ / 1000000) * SPEED_WIN_US;
  localparam int SPEED_MIN_PULSES = 40;
  localparam int CAPTURE_BITS   = 5;
  localparam int THRESH_PCT     = 30;
  localparam int PEAK_W         = 8;
  localparam int IRQ_W          = 4;
  localparam logic [3:0] IRQ_BIT_VIOL   = 4'h1;
  localparam logic [3:0] IRQ_BIT_NRDY   = 4'h2;
  localparam logic [3:0] IRQ_BIT_CAPT   = 4'h4;
  localparam logic [3:0] IRQ_BIT_RELS   = 4'h8;
  localparam logic [1:0] REG_PROTECT    = 2'h0;
  localparam logic [1:0] REG_STATUS     = 2'h1;
  localparam logic [1:0] REG_IRQ_STAT   = 2'h2;
  localparam logic [1:0] REG_IRQ_MASK   = 2'h3;
  localparam logic [15:0] PROTECT_RESET = 16'h0000;
  localparam logic [3:0]  MASK_RESET    = 4'h0;

  typedef enum logic [1:0] {TWLR_IDLE, TWLR_CAPTURE, TWLR_HOLD, TWLR_RELEASE} twlr_peak_t;

endpackage : twlr_pkg

// ### src/twlr_track_write_lockout_ready.sv
// Track write lockout, ready qualification and peak sampler sequencing.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// RULE_01 - Upper four track address bits pick one of sixteen groups of sixteen tracks.
// RULE_02 - A protected group raises the violation internally and on the controller output.
// RULE_03 - A violation cuts write power and current but never drops ready.
// RULE_04 - Ready holds only while three supplies are good, speed is good, bus terminated.
// RULE_05 - Ready goes to interface and bus; not ready removes write driver power.
// RULE_06 - At speed means clock track pulse rate meets a fixed reference rate.
// RULE_07 - At preamble start the peak capture window opens for five bit times.
// RULE_08 - Peak is held afterwards; thirty percent of it forms the read threshold.
// RULE_09 - At read end the release control clears the held peak.
// RULE_10 - Not ready resets write enable delay chain; violations also disable writing.
// RULE_11 - Ready and violation outputs are active low on both sides.
module twlr_track_write_lockout_ready #(
  parameter int SPEED_WIN_CYC = twlr_pkg::SPEED_WIN_CYC,
  parameter int SPEED_MIN     = twlr_pkg::SPEED_MIN_PULSES,
  parameter int WEN_DELAY     = 8
) (
  input  wire logic                          clk,
  input  wire logic                          rstn,
  input  wire logic [twlr_pkg::TRACK_W-1:0]  trackAddr,
  input  wire logic                          writeReq,
  input  wire logic                          readReq,
  input  wire logic                          bitTick,
  input  wire logic [twlr_pkg::SUPPLY_COUNT-1:0] supplyOk,
  input  wire logic                          busTerminated,
  input  wire logic                          clockTrackPulse,
  input  wire logic                          preambleStart,
  input  wire logic [twlr_pkg::PEAK_W-1:0]   peakLevel,
  input  wire logic [1:0]                    regAddr,
  input  wire logic [15:0]                   regWdata,
  input  wire logic                          regWrite,
  input  wire logic                          regRead,
  output logic [15:0]                        regRdata,
  output logic                               discReadyN,
  output logic                               illegalAddrN,
  output logic                               writeDriverPower,
  output logic                               writeCurrent,
  output logic                               captureWindow,
  output logic                               peakRelease,
  output logic [twlr_pkg::PEAK_W-1:0]        threshold,
  output logic                               irq
);

  // ==========================================================
  // Shared decoding
  // ==========================================================
  // The lockout path and its assertions share one group decode so that they cannot drift apart.
  function automatic logic [3:0] group_of(input logic [twlr_pkg::TRACK_W-1:0] addr);
    return addr[twlr_pkg::GROUP_LSB +: 4];
  endfunction : group_of

  // ==========================================================
  // Input synchronisers
  // ==========================================================
  logic [twlr_pkg::SUPPLY_COUNT+1:0] syncA_reg;
  logic [twlr_pkg::SUPPLY_COUNT+1:0] syncB_reg;
  logic                              pulseLast_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      syncA_reg     <= '0;
      syncB_reg     <= '0;
      pulseLast_reg <= 1'b0;
    end else begin
      syncA_reg     <= {clockTrackPulse, busTerminated, supplyOk};
      syncB_reg     <= syncA_reg;
      pulseLast_reg <= syncB_reg[twlr_pkg::SUPPLY_COUNT+1];
    end
  end

  wire logic pulseEdge = syncB_reg[twlr_pkg::SUPPLY_COUNT+1] & ~pulseLast_reg;

  // ==========================================================
  // Speed monitor
  // ==========================================================
  // The window keeps the previous verdict until it closes, trading response time for noise immunity.
  logic [15:0] winCnt_reg;
  logic [15:0] pulseCnt_reg;
  logic        atSpeed_reg;
  wire logic   winEnd = (winCnt_reg == 16'(SPEED_WIN_CYC - 1));

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      winCnt_reg   <= '0;
      pulseCnt_reg <= '0;
      atSpeed_reg  <= 1'b0;
    end else begin
      winCnt_reg   <= winEnd ? 16'h0000 : winCnt_reg + 16'h0001;
      pulseCnt_reg <= winEnd ? 16'h0000 : pulseCnt_reg + {15'h0000, pulseEdge};
      if (winEnd) begin
        atSpeed_reg <= (pulseCnt_reg >= 16'(SPEED_MIN)); // RULE_06
      end
    end
  end

  // ==========================================================
  // Ready, lockout and write gating
  // ==========================================================
  logic [15:0] protect_reg;
  logic        ready_reg;
  logic        viol_reg;
  logic [WEN_DELAY-1:0] wenChain_reg;

  wire logic [3:0] groupSel = group_of(trackAddr); // RULE_01
  wire logic       violNext = protect_reg[groupSel]; // RULE_02
  wire logic       readyNext = &syncB_reg[twlr_pkg::SUPPLY_COUNT:0] & atSpeed_reg; // RULE_04
  wire logic       writeOk = ready_reg & ~viol_reg; // RULE_03

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ready_reg    <= 1'b0;
      viol_reg     <= 1'b0;
      wenChain_reg <= '0;
    end else begin
      ready_reg <= readyNext;
      viol_reg  <= violNext;
      if (!ready_reg) begin
        wenChain_reg <= '0; // RULE_10
      end else if (bitTick) begin
        wenChain_reg <= {wenChain_reg[WEN_DELAY-2:0], writeReq};
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      discReadyN       <= 1'b1;
      illegalAddrN     <= 1'b1;
      writeDriverPower <= 1'b0;
      writeCurrent     <= 1'b0;
    end else begin
      discReadyN       <= ~ready_reg; // RULE_05 RULE_11
      illegalAddrN     <= ~viol_reg; // RULE_11
      writeDriverPower <= writeOk; // RULE_05
      writeCurrent     <= writeOk & (writeReq | (|wenChain_reg)); // RULE_10
    end
  end

  // ==========================================================
  // Peak sampler sequencing
  // ==========================================================
  twlr_pkg::twlr_peak_t peakState_reg;
  logic [2:0]            bitCnt_reg;
  logic [twlr_pkg::PEAK_W-1:0] peakHold_reg;
  logic                  readLast_reg;
  wire logic             readEnd = readLast_reg & ~readReq;
  wire logic             capDone = bitTick && (bitCnt_reg == 3'(twlr_pkg::CAPTURE_BITS - 1));

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      peakState_reg <= twlr_pkg::TWLR_IDLE;
      bitCnt_reg    <= '0;
      peakHold_reg  <= '0;
      readLast_reg  <= 1'b0;
    end else begin
      readLast_reg <= readReq;
      unique case (peakState_reg)
        twlr_pkg::TWLR_IDLE: begin
          bitCnt_reg <= '0;
          if (readReq && preambleStart) begin
            peakState_reg <= twlr_pkg::TWLR_CAPTURE; // RULE_07
          end
        end
        twlr_pkg::TWLR_CAPTURE: begin
          if (peakLevel > peakHold_reg) begin
            peakHold_reg <= peakLevel;
          end
          if (bitTick) begin
            bitCnt_reg <= bitCnt_reg + 3'h1;
          end
          if (readEnd) begin
            peakState_reg <= twlr_pkg::TWLR_RELEASE;
          end else if (capDone) begin
            peakState_reg <= twlr_pkg::TWLR_HOLD; // RULE_07
          end
        end
        twlr_pkg::TWLR_HOLD: begin
          if (readEnd) begin
            peakState_reg <= twlr_pkg::TWLR_RELEASE; // RULE_09
          end
        end
        twlr_pkg::TWLR_RELEASE: begin
          peakHold_reg  <= '0; // RULE_09
          peakState_reg <= twlr_pkg::TWLR_IDLE;
        end
      endcase
    end
  end

  wire logic [15:0] threshProd = 16'(peakHold_reg) * 16'(twlr_pkg::THRESH_PCT);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      captureWindow <= 1'b0;
      peakRelease   <= 1'b0;
      threshold     <= '0;
    end else begin
      captureWindow <= (peakState_reg == twlr_pkg::TWLR_CAPTURE);
      peakRelease   <= (peakState_reg == twlr_pkg::TWLR_RELEASE);
      threshold     <= twlr_pkg::PEAK_W'(threshProd / 16'h0064); // RULE_08
    end
  end

  // ==========================================================
  // Registers and interrupts
  // ==========================================================
  logic [3:0] irqStat_reg;
  logic [3:0] irqMask_reg;
  logic [3:0] evt;
  assign evt = {peakState_reg == twlr_pkg::TWLR_RELEASE, capDone && peakState_reg == twlr_pkg::TWLR_CAPTURE,
                ready_reg & ~readyNext, violNext & ~viol_reg};

  wire logic       wrProt = regWrite && (regAddr == twlr_pkg::REG_PROTECT);
  wire logic       wrStat = regWrite && (regAddr == twlr_pkg::REG_IRQ_STAT);
  wire logic       wrMask = regWrite && (regAddr == twlr_pkg::REG_IRQ_MASK);
  wire logic [3:0] statClr = wrStat ? regWdata[3:0] : 4'h0;
  wire logic [15:0] statusWord = {11'h000, readEnd, viol_reg, ready_reg, atSpeed_reg, captureWindow};
  wire logic [15:0] rdMux = (regAddr == twlr_pkg::REG_PROTECT)  ? protect_reg :
                            (regAddr == twlr_pkg::REG_STATUS)   ? statusWord :
                            (regAddr == twlr_pkg::REG_IRQ_STAT) ? {12'h000, irqStat_reg} :
                                                                  {12'h000, irqMask_reg};

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      protect_reg <= twlr_pkg::PROTECT_RESET;
      irqStat_reg <= '0;
      irqMask_reg <= twlr_pkg::MASK_RESET;
      regRdata    <= '0;
      irq         <= 1'b0;
    end else begin
      if (wrProt) begin
        protect_reg <= regWdata;
      end
      if (wrMask) begin
        irqMask_reg <= regWdata[3:0];
      end
      irqStat_reg <= (irqStat_reg & ~statClr) | evt;
      regRdata    <= regRead ? rdMux : 16'h0000;
      irq         <= |(irqStat_reg & irqMask_reg);
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  // Counts bit times spent in capture so that the window length is checked independently of the state counter.
  logic [3:0] capTicks_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      capTicks_reg <= '0;
    end else if (peakState_reg != twlr_pkg::TWLR_CAPTURE) begin
      capTicks_reg <= '0;
    end else if (bitTick) begin
      capTicks_reg <= capTicks_reg + 4'h1;
    end
  end

  a_viol_no_power: assert property (@(posedge clk) disable iff (!rstn) // RULE_03
    viol_reg |=> !writeDriverPower && !writeCurrent)
    else $error("Violation left write power on.");

  a_viol_keeps_ready: assert property (@(posedge clk) disable iff (!rstn) // RULE_03
    ready_reg && viol_reg |=> !discReadyN)
    else $error("Violation dropped ready.");

  a_ready_cause: assert property (@(posedge clk) disable iff (!rstn) // RULE_04
    !readyNext |=> ##1 discReadyN)
    else $error("Ready without all conditions.");

  a_nrdy_no_power: assert property (@(posedge clk) disable iff (!rstn) // RULE_05
    !ready_reg |=> !writeDriverPower)
    else $error("Not ready left write power on.");

  a_nrdy_chain: assert property (@(posedge clk) disable iff (!rstn) // RULE_10
    !ready_reg |=> wenChain_reg == '0)
    else $error("Delay chain not reset.");

  a_nrdy_no_current: assert property (@(posedge clk) disable iff (!rstn) // RULE_10
    !ready_reg |=> !writeCurrent)
    else $error("Not ready left write current on.");

  a_group_decode: assert property (@(posedge clk) disable iff (!rstn) // RULE_02
    protect_reg[group_of(trackAddr)] |=> ##1 !illegalAddrN)
    else $error("Protected group not flagged.");

  a_group_clear: assert property (@(posedge clk) disable iff (!rstn) // RULE_02
    !protect_reg[group_of(trackAddr)] |=> ##1 illegalAddrN)
    else $error("Open group flagged as violation.");

  a_ready_speed: assert property (@(posedge clk) disable iff (!rstn) // RULE_06
    !atSpeed_reg |=> !ready_reg)
    else $error("Ready without speed.");

  a_capture_len: assert property (@(posedge clk) disable iff (!rstn) // RULE_07
    $rose(peakState_reg == twlr_pkg::TWLR_CAPTURE) |-> bitCnt_reg == 3'h0)
    else $error("Capture count not cleared.");

  a_capture_five: assert property (@(posedge clk) disable iff (!rstn) // RULE_07
    peakState_reg == twlr_pkg::TWLR_HOLD && $past(peakState_reg) == twlr_pkg::TWLR_CAPTURE
    |-> capTicks_reg == 4'(twlr_pkg::CAPTURE_BITS))
    else $error("Capture window closed early.");

  a_capture_bound: assert property (@(posedge clk) disable iff (!rstn) // RULE_07
    peakState_reg == twlr_pkg::TWLR_CAPTURE |-> capTicks_reg < 4'(twlr_pkg::CAPTURE_BITS))
    else $error("Capture window ran too long.");

  a_hold_stable: assert property (@(posedge clk) disable iff (!rstn) // RULE_08
    peakState_reg == twlr_pkg::TWLR_HOLD && $past(peakState_reg) == twlr_pkg::TWLR_HOLD |-> $stable(peakHold_reg))
    else $error("Held peak changed.");

  a_hold_thresh: assert property (@(posedge clk) disable iff (!rstn) // RULE_08
    peakState_reg == twlr_pkg::TWLR_HOLD && $past(peakState_reg) == twlr_pkg::TWLR_HOLD |=> $stable(threshold))
    else $error("Threshold moved during hold.");

  a_release_clear: assert property (@(posedge clk) disable iff (!rstn) // RULE_09
    peakState_reg == twlr_pkg::TWLR_RELEASE |=> peakHold_reg == '0 && peakRelease)
    else $error("Release did not clear.");

  a_release_pulse: assert property (@(posedge clk) disable iff (!rstn) // RULE_09
    peakRelease |=> !peakRelease)
    else $error("Release control stuck high.");

  a_irq_level: assert property (@(posedge clk) disable iff (!rstn)
    |(irqStat_reg & irqMask_reg) |=> irq)
    else $error("Unmasked status gave no interrupt.");

  a_sticky_set: assert property (@(posedge clk) disable iff (!rstn)
    |evt |=> (irqStat_reg & $past(evt)) == $past(evt))
    else $error("Event did not set its status bit.");

  a_clear_w1c: assert property (@(posedge clk) disable iff (!rstn)
    wrStat |=> (irqStat_reg & $past(statClr & ~evt)) == 4'h0)
    else $error("Status bit not cleared by write.");

  a_rdata_idle: assert property (@(posedge clk) disable iff (!rstn)
    !regRead |=> regRdata == 16'h0000)
    else $error("Read data without a read.");

  // Covers mark the main scenarios: a violation, ready, a full capture and a release.
  c_violation: cover property (@(posedge clk) disable iff (!rstn) $fell(illegalAddrN));
  c_ready: cover property (@(posedge clk) disable iff (!rstn) $fell(discReadyN));
  c_capture: cover property (@(posedge clk) disable iff (!rstn) $fell(captureWindow));
  c_capture_done: cover property (@(posedge clk) disable iff (!rstn)
    peakState_reg == twlr_pkg::TWLR_HOLD && $past(peakState_reg) == twlr_pkg::TWLR_CAPTURE);
  c_release: cover property (@(posedge clk) disable iff (!rstn) peakRelease);

endmodule : twlr_track_write_lockout_ready

`default_nettype wire

// ### tb/twlr_ctrl_model.sv
// Behavioural model of the external disc controller that drives track address and write.
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Controller model
module twlr_ctrl_model (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic [7:0] goTrack,
  input  wire logic       goWrite,
  input  wire logic       discReadyN,
  input  wire logic       illegalAddrN,
  output var  logic [7:0] trackAddr,
  output var  logic       writeReq,
  output var  logic       sawIllegal
);
  // A real controller only asks for a write while the unit reports ready, so neither does this one.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      trackAddr  <= 8'h00;
      writeReq   <= 1'b0;
      sawIllegal <= 1'b0;
    end else begin
      trackAddr  <= goTrack;
      writeReq   <= goWrite & ~discReadyN;
      sawIllegal <= ~illegalAddrN;
    end
  end
endmodule : twlr_ctrl_model
`default_nettype wire

// ### tb/testbench.sv
// Self-checking testbench for the track write lockout and ready block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk = 1'b0, rstn = 1'b0, goWrite = 1'b0, readReq = 1'b0, bitTick = 1'b0;
  logic        busTerminated = 1'b1, speedOn = 1'b1, clockTrackPulse = 1'b0, preambleStart = 1'b0;
  logic        regWrite = 1'b0, regRead = 1'b0;
  logic [2:0]  supplyOk = 3'h7;
  logic [7:0]  goTrack = 8'h00, peakLevel = 8'h00, v;
  logic [1:0]  regAddr = 2'h0;
  logic [15:0] regWdata = 16'h0000, mask;
  logic [31:0] lfsr = 32'hd580;
  wire  [7:0]  trackAddr, threshold;
  wire  [15:0] regRdata;
  wire         writeReq, discReadyN, illegalAddrN, writeDriverPower, writeCurrent;
  wire         captureWindow, peakRelease, irq, sawIllegal;
  int          miscompares = 0, n_checks = 0, g, p, c, cnt;
  always #12.5 clk = ~clk;
  // A toggle every cycle gives twenty rising pulses per shortened speed window.
  always @(posedge clk) clockTrackPulse <= speedOn & ~clockTrackPulse;
  twlr_track_write_lockout_ready #(.SPEED_WIN_CYC(40), .SPEED_MIN(4), .WEN_DELAY(8)) uut (
    .clk(clk), .rstn(rstn), .trackAddr(trackAddr), .writeReq(writeReq), .readReq(readReq),
    .bitTick(bitTick), .supplyOk(supplyOk), .busTerminated(busTerminated),
    .clockTrackPulse(clockTrackPulse), .preambleStart(preambleStart), .peakLevel(peakLevel),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .discReadyN(discReadyN), .illegalAddrN(illegalAddrN),
    .writeDriverPower(writeDriverPower), .writeCurrent(writeCurrent),
    .captureWindow(captureWindow), .peakRelease(peakRelease), .threshold(threshold), .irq(irq));
  twlr_ctrl_model ctrl (.clk(clk), .rstn(rstn), .goTrack(goTrack), .goWrite(goWrite),
    .discReadyN(discReadyN), .illegalAddrN(illegalAddrN), .trackAddr(trackAddr),
    .writeReq(writeReq), .sawIllegal(sawIllegal));
  // ==========================================
  // Shared tasks
  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : step
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk) begin regAddr <= a; regWdata <= d; regWrite <= 1'b1; end
    @(posedge clk) regWrite <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, input logic [15:0] exp);
    @(posedge clk) begin regAddr <= a; regRead <= 1'b1; end
    @(posedge clk) regRead <= 1'b0;
    #1 check("regRdata", regRdata, exp);
  endtask : rd
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle
  task automatic wait_ready(input logic want);
    for (int i = 0; i < 300 && discReadyN !== want; i++) settle(1);
    #1 check("discReadyN", {15'h0, discReadyN}, {15'h0, want});
  endtask : wait_ready
  task automatic stop_test;
    if (miscompares == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  initial begin
    #(25 * 20000) miscompares++;
    stop_test();
  end
  // ==========================================
  // Main sequence
  initial begin
    settle(15);
    check("resetOuts", {illegalAddrN, discReadyN, writeDriverPower, writeCurrent}, 4'hc);
    @(posedge clk) rstn <= 1'b1;
    rd(twlr_pkg::REG_PROTECT, twlr_pkg::PROTECT_RESET);
    rd(twlr_pkg::REG_IRQ_MASK, {12'h0, twlr_pkg::MASK_RESET});
    wait_ready(1'b0);
    lfsr = step(lfsr);
    mask = lfsr[15:0];
    @(posedge clk) goWrite <= 1'b1;
    for (p = 0; p < 2; p++) begin
      mask = p ? ~mask : mask;
      wr(twlr_pkg::REG_PROTECT, mask);
      rd(twlr_pkg::REG_PROTECT, mask);
      for (g = 0; g < 16; g++) begin
        lfsr = step(lfsr);
        @(posedge clk) goTrack <= {g[3:0], g == 15 ? 4'hf : g == 0 ? 4'h0 : lfsr[3:0]};
        settle(8);
        check("illegalAddrN", {15'h0, illegalAddrN}, {15'h0, ~mask[g]});
        check("sawIllegal", {15'h0, sawIllegal}, {15'h0, mask[g]});
        check("writeDriverPower", {15'h0, writeDriverPower}, {15'h0, ~mask[g]});
        check("writeCurrent", {15'h0, writeCurrent}, {15'h0, ~mask[g]});
        check("discReadyN", {15'h0, discReadyN}, 16'h0);
      end
    end
    wr(twlr_pkg::REG_PROTECT, 16'h0001);
    wr(twlr_pkg::REG_IRQ_MASK, 16'h0);
    @(posedge clk) goTrack <= 8'h20;
    settle(6);
    wr(twlr_pkg::REG_IRQ_STAT, 16'h000f);
    @(posedge clk) goTrack <= 8'h05;
    settle(6);
    check("irqMasked", {15'h0, irq}, 16'h0);
    rd(twlr_pkg::REG_IRQ_STAT, {12'h0, twlr_pkg::IRQ_BIT_VIOL});
    rd(twlr_pkg::REG_STATUS, 16'h000e);
    wr(twlr_pkg::REG_IRQ_MASK, {12'h0, twlr_pkg::IRQ_BIT_VIOL});
    settle(2);
    check("irqRaised", {15'h0, irq}, 16'h1);
    wr(twlr_pkg::REG_IRQ_STAT, {12'h0, twlr_pkg::IRQ_BIT_VIOL});
    settle(2);
    check("irqCleared", {15'h0, irq}, 16'h0);
    // Peak sampler: the level rises after capture so a missing hold shows in the threshold.
    lfsr = step(lfsr);
    v = (lfsr[7:0] & 8'h7f) | 8'h40;
    @(posedge clk) begin goTrack <= 8'h20; goWrite <= 1'b0; readReq <= 1'b1; peakLevel <= v; end
    @(posedge clk) preambleStart <= 1'b1;
    @(posedge clk) preambleStart <= 1'b0;
    for (int i = 0; i < 20 && captureWindow !== 1'b1; i++) settle(1);
    cnt = 0;
    repeat (7) begin
      @(posedge clk) bitTick <= 1'b1;
      #1 cnt += (captureWindow === 1'b1);
      @(posedge clk) bitTick <= 1'b0;
      repeat (2) @(posedge clk);
    end
    check("captureTicks", cnt[15:0], 16'h0005);
    @(posedge clk) peakLevel <= 8'hff;
    settle(8);
    check("threshold", {8'h0, threshold}, 16'(int'(v) * twlr_pkg::THRESH_PCT / 100));
    @(posedge clk) readReq <= 1'b0;
    cnt = 0;
    repeat (10) begin
      @(posedge clk);
      #1 cnt += (peakRelease === 1'b1);
    end
    check("peakRelease", cnt[15:0], 16'd1);
    check("thresholdCleared", {8'h0, threshold}, 16'h0);
    rd(twlr_pkg::REG_IRQ_STAT, {12'h0, twlr_pkg::IRQ_BIT_CAPT | twlr_pkg::IRQ_BIT_RELS});
    // Each of the five ready conditions is taken away in turn.
    @(posedge clk) goWrite <= 1'b1;
    for (c = 0; c < 5; c++) begin
      @(posedge clk) {busTerminated, speedOn, supplyOk} <= 5'h1f ^ (5'h01 << c);
      wait_ready(1'b1);
      settle(3);
      check("powerNotReady", {14'h0, writeDriverPower, writeCurrent}, 16'h0);
      @(posedge clk) {busTerminated, speedOn, supplyOk} <= 5'h1f;
      wait_ready(1'b0);
      settle(3);
      check("powerReady", {15'h0, writeDriverPower}, 16'h1);
    end
    rd(twlr_pkg::REG_IRQ_STAT, {12'h0, twlr_pkg::IRQ_BIT_NRDY | twlr_pkg::IRQ_BIT_CAPT | twlr_pkg::IRQ_BIT_RELS});
    stop_test();
  end
endmodule : testbench
`default_nettype wire
